// *** spt_pkg.sv ***
package spt_pkg;

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W     = 10;
  localparam int unsigned DATA_W     = 32;
  localparam int unsigned IDX_LSB    = 2;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // Register index; byte address is four times the index
  localparam logic [7:0] IDX_DATA  = 8'h08;
  localparam logic [7:0] IDX_PINS  = 8'h09;
  localparam logic [7:0] IDX_FLAGS = 8'h0c;
  localparam logic [7:0] IDX_DDIR  = 8'h88;
  localparam logic [7:0] IDX_CTRL  = 8'h89;
  localparam logic [7:0] IDX_EN    = 8'h8c;
  localparam logic [7:0] IDX_ANCFG = 8'h9f;

  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam int unsigned B_IBF   = 7;
  localparam int unsigned B_OBF   = 6;
  localparam int unsigned B_OVF   = 5;
  localparam int unsigned B_MODE  = 4;
  localparam int unsigned B_IRQ   = 7;
  localparam int unsigned PIN_RD  = 0;
  localparam int unsigned PIN_WR  = 1;
  localparam int unsigned PIN_CS  = 2;
  localparam int unsigned CTL_W   = 3;
  localparam int unsigned BUS_W   = 8;

  localparam logic [7:0] CTRL_RST   = 8'h07;
  localparam logic [7:0] FLAGS_RST  = 8'h00;
  localparam logic [7:0] EN_RST     = 8'h00;
  localparam logic [7:0] ANCFG_RST  = 8'h00;
  localparam logic [7:0] ANCFG_MASK = 8'h8f;
  localparam logic [7:0] DDIR_RST   = 8'hff;
  localparam logic [7:0] DATA_RST   = 8'h00;
  localparam logic [7:0] BUS_IDLE   = 8'hff;
  localparam logic [2:0] CTL_IDLE   = 3'h7;

  // ----------------------------------------------------------------
  // Host strobe timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_NS     = 100;
  localparam int unsigned STROBE_NS  = 800;
  localparam int unsigned RECOV_NS   = 300;
  localparam int unsigned STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned RECOV_CYC  = (RECOV_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned CNT_W      = 4;

  typedef enum logic [1:0] {
    SPT_IDLE  = 2'b00,
    SPT_SETUP = 2'b01,
    SPT_STRB  = 2'b10,
    SPT_RECOV = 2'b11
  } spt_host_st_t;

endpackage : spt_pkg

// *** spt_if.sv ***
`timescale 1ns/100ps
`default_nettype none

interface spt_if;
  logic [7:0] d_dev_o;   // Device data drive
  logic [7:0] d_dev_oe;  // Device data enables
  logic [7:0] d_host_o;  // Host data drive
  logic       d_host_oe; // Host data enable
  logic [2:0] c_dev_o;   // Device control-pin drive
  logic [2:0] c_dev_oe;  // Device control-pin enables
  logic [2:0] c_host_o;  // Host {select, write, read}, low active
  logic       c_host_oe; // Host control enable
  logic [7:0] d_bus;     // Resolved data wires
  logic [2:0] c_bus;     // Resolved control wires

  // Undriven wires float high through pull-ups
  assign d_bus = (d_dev_oe & d_dev_o)
               | (~d_dev_oe & (d_host_oe ? d_host_o : 8'hff));
  assign c_bus = (c_dev_oe & c_dev_o)
               | (~c_dev_oe & (c_host_oe ? c_host_o : 3'h7));

  modport dev (
    input  d_bus, c_bus,
    output d_dev_o, d_dev_oe, c_dev_o, c_dev_oe
  );
  modport host (
    input  d_bus, c_bus,
    output d_host_o, d_host_oe, c_host_o, c_host_oe
  );
endinterface : spt_if

`default_nettype wire

// *** spt_device.sv ***
// Function
// R1: Mode bit selects slave port or GPIO
// R2: Input-full shows unread received word
// R3: Output-full shows word not yet fetched
// R4: Write onto unread word sets sticky overflow
// R5: Port E pin 0 is read strobe
// R6: Port E pin 1 is write strobe
// R7: Port E pin 2 is select, always needed
// R8: Port D is slave bus or GPIO
// R9: Low control bits set pin directions
// R10: Control bit 3 reads zero, ignores writes
// R11: Without slave port, its registers read zero
// R12: Without slave port, software keeps irq bits clear
// R13: External write latches word, sets flags
// R14: CPU write sets output-full, external read clears
`timescale 1ns/100ps
`default_nettype none

module spt_device #(
  parameter bit HAS_PORT = 1'b1
) (
  input  wire logic                       i_mclk,    // System clock
  input  wire logic                       i_rst,     // Sync reset
  input  wire logic [spt_pkg::ADDR_W-1:0] i_awaddr,  // Write address
  input  wire logic                       i_awvalid, // Address valid
  output logic                            o_awready, // Address taken
  input  wire logic [spt_pkg::DATA_W-1:0] i_wdata,   // Write data
  input  wire logic [3:0]                 i_wstrb,   // Byte enables
  input  wire logic                       i_wvalid,  // Data valid
  output logic                            o_wready,  // Data taken
  output logic [1:0]                      o_bresp,   // Write response
  output logic                            o_bvalid,  // Response valid
  input  wire logic                       i_bready,  // Response taken
  input  wire logic [spt_pkg::ADDR_W-1:0] i_araddr,  // Read address
  input  wire logic                       i_arvalid, // Address valid
  output logic                            o_arready, // Address taken
  output logic [spt_pkg::DATA_W-1:0]      o_rdata,   // Read data
  output logic [1:0]                      o_rresp,   // Read response
  output logic                            o_rvalid,  // Read valid
  input  wire logic                       i_rready,  // Read taken
  output logic                            o_irq,     // Interrupt level
  spt_if.dev                              pins       // Port pins
);
  import spt_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0] d_s1;
  logic [7:0] d_s2;
  logic [2:0] c_s1;
  logic [2:0] c_s2;
  logic [2:0] c_s3;
  logic [7:0] cap;
  logic [7:0] in_buf;
  logic [7:0] out_buf;
  logic       input_full;
  logic       output_full;
  logic       input_overflow;
  logic       slave_mode_select;
  logic [2:0] edir;
  logic [2:0] eout;
  logic [7:0] ddir;
  logic       slave_port_irq_flag;
  logic [7:0] irq_en;
  logic [7:0] ancfg;
  logic [7:0] rval;
  logic       next_ibf;
  logic       next_obf;
  logic       next_ovf;
  logic       next_flag;

  function automatic logic mapped(input logic [7:0] idx);
    return (idx == IDX_DATA) || (idx == IDX_PINS) ||
           (idx == IDX_FLAGS) || (idx == IDX_DDIR) ||
           (idx == IDX_CTRL) || (idx == IDX_EN) ||
           (idx == IDX_ANCFG);
  endfunction : mapped

  function automatic logic low(input logic [2:0] c, input int p);
    return ~c[p] & ~c[PIN_CS];
  endfunction : low

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Strobes come from another clock; levels are read on stage two, edges on stages two and three
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      d_s1 <= BUS_IDLE;
      d_s2 <= BUS_IDLE;
      c_s1 <= CTL_IDLE;
      c_s2 <= CTL_IDLE;
      c_s3 <= CTL_IDLE;
    end
    else
    begin
      d_s1 <= pins.d_bus;
      d_s2 <= d_s1;
      c_s1 <= pins.c_bus;
      c_s2 <= c_s1;
      c_s3 <= c_s2;
    end
  end

  wire en_port = HAS_PORT & slave_mode_select;
  wire rd_act  = en_port & low(c_s2, PIN_RD);   // [R5] [R7]
  wire rd_prev = en_port & low(c_s3, PIN_RD);
  wire wr_act  = en_port & low(c_s2, PIN_WR);   // [R6] [R7]
  wire wr_prev = en_port & low(c_s3, PIN_WR);
  wire rd_done = rd_prev & ~rd_act;
  wire wr_done = wr_prev & ~wr_act;

  // ----------------------------------------------------------------
  // AXI4-Lite decode
  // ----------------------------------------------------------------
  wire       wr_go  = i_awvalid & i_wvalid & ~o_bvalid;
  wire [7:0] widx   = i_awaddr[IDX_LSB +: 8];
  wire       wen    = wr_go & i_wstrb[0];
  wire [7:0] wb     = i_wdata[7:0];
  wire       w_data = wen & (widx == IDX_DATA);
  wire       w_pins = wen & (widx == IDX_PINS);
  wire       w_ddir = wen & (widx == IDX_DDIR);
  wire       w_ctrl = wen & (widx == IDX_CTRL);
  wire       w_en   = wen & (widx == IDX_EN);
  wire       w_anc  = wen & (widx == IDX_ANCFG);
  wire       rd_go  = i_arvalid & ~o_rvalid;
  wire [7:0] ridx   = i_araddr[IDX_LSB +: 8];
  wire       r_data = rd_go & (ridx == IDX_DATA) & en_port;
  wire       r_flag = rd_go & (ridx == IDX_FLAGS);

  assign o_awready = wr_go;
  assign o_wready  = wr_go;
  assign o_arready = rd_go;

  always_comb
  begin
    rval = 8'h00;
    case (ridx)
      IDX_DATA:  rval = slave_mode_select ? in_buf : d_s2; // [R8]
      IDX_PINS:  rval = {5'h00, c_s2};
      IDX_FLAGS: rval = {slave_port_irq_flag, 7'h00};
      IDX_DDIR:  rval = ddir;
      IDX_CTRL:  rval = {input_full, output_full, input_overflow,
                         slave_mode_select, 1'b0, edir}; // [R10]
      IDX_EN:    rval = irq_en;
      IDX_ANCFG: rval = ancfg;
      default:   rval = 8'h00;
    endcase
    if (!HAS_PORT && ridx != IDX_FLAGS && ridx != IDX_EN &&
        ridx != IDX_ANCFG)
      rval = 8'h00; // [R11]
  end

  // ----------------------------------------------------------------
  // Port status flags; a hardware set beats a clear
  // ----------------------------------------------------------------
  assign next_ibf  = wr_done | (input_full & ~r_data);   // [R2] [R13]
  assign next_ovf  = (wr_done & input_full & ~r_data)
                   | (w_ctrl ? wb[B_OVF] : input_overflow); // [R4]
  assign next_obf  = (w_data & en_port)
                   | (output_full & ~rd_done);          // [R3] [R14]
  assign next_flag = wr_done | (slave_port_irq_flag & ~r_flag); // [R13]

  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      input_full          <= CTRL_RST[B_IBF];
      output_full         <= CTRL_RST[B_OBF];
      input_overflow      <= CTRL_RST[B_OVF];
      slave_port_irq_flag <= FLAGS_RST[B_IRQ];
    end
    else
    begin
      input_full          <= next_ibf;
      output_full         <= next_obf;
      input_overflow      <= next_ovf;
      slave_port_irq_flag <= next_flag;
    end
  end

  // Word sampled while the strobe is low; the last sample wins
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      cap    <= DATA_RST;
      in_buf <= DATA_RST;
    end
    else
    begin
      if (wr_act)
        cap <= d_s2;
      if (wr_done)
        in_buf <= cap; // [R13]
    end
  end

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      slave_mode_select <= CTRL_RST[B_MODE];
      edir              <= CTRL_RST[CTL_W-1:0];
      eout              <= DATA_RST[CTL_W-1:0];
      out_buf           <= DATA_RST;
      ddir              <= DDIR_RST;
      irq_en            <= EN_RST;
      ancfg             <= ANCFG_RST;
    end
    else
    begin
      if (w_ctrl)
      begin
        slave_mode_select <= wb[B_MODE];   // [R1]
        edir              <= wb[CTL_W-1:0]; // [R9]
      end
      if (w_data)
        out_buf <= wb; // [R14]
      if (w_pins)
        eout <= wb[CTL_W-1:0];
      if (w_ddir)
        ddir <= wb;
      if (w_en)
        irq_en <= wb;
      if (w_anc)
        ancfg <= wb & ANCFG_MASK;
    end
  end

  // ----------------------------------------------------------------
  // Bus answers
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      o_bvalid <= 1'b0;
      o_bresp  <= RESP_OKAY;
      o_rvalid <= 1'b0;
      o_rresp  <= RESP_OKAY;
      o_rdata  <= '0;
    end
    else
    begin
      if (wr_go)
      begin
        o_bvalid <= 1'b1;
        o_bresp  <= mapped(widx) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (i_bready)
        o_bvalid <= 1'b0;
      if (rd_go)
      begin
        o_rvalid <= 1'b1;
        o_rresp  <= mapped(ridx) ? RESP_OKAY : RESP_SLVERR;
        o_rdata  <= {{(DATA_W-8){1'b0}}, rval};
      end
      else if (i_rready)
        o_rvalid <= 1'b0;
    end
  end

  assign o_irq = slave_port_irq_flag & irq_en[B_IRQ];

  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  // In slave mode port E is forced to input whatever its direction bits
  assign pins.d_dev_o  = out_buf;
  assign pins.d_dev_oe = !HAS_PORT ? 8'h00 :
                         slave_mode_select ? {BUS_W{rd_act}} :
                         ~ddir; // [R8] [R14]
  assign pins.c_dev_o  = eout;
  assign pins.c_dev_oe = (HAS_PORT && !slave_mode_select) ?
                         ~edir : 3'h0; // [R1] [R9]

endmodule : spt_device

`default_nettype wire

// *** spt_host.sv ***
`timescale 1ns/100ps
`default_nettype none

module spt_host #(
  parameter int unsigned STRB_CYC  = spt_pkg::STROBE_CYC,
  parameter int unsigned RECOV_LEN = spt_pkg::RECOV_CYC
) (
  input  wire logic       i_mclk,  // System clock
  input  wire logic       i_rst,   // Sync reset
  input  wire logic       i_req,   // Transfer request
  input  wire logic       i_write, // 1 write, 0 read
  input  wire logic [7:0] i_wdata, // Word to write
  output logic            o_busy,  // Transfer under way
  output logic            o_done,  // One-cycle end pulse
  output logic [7:0]      o_rdata, // Word read
  spt_if.host             pins     // Port pins
);
  import spt_pkg::*;

  spt_host_st_t     st;
  spt_host_st_t     next_st;
  logic [CNT_W-1:0] cnt;
  logic             wr_mode;
  logic [7:0]       d_s1;
  logic [7:0]       d_s2;
  logic [2:0]       ctl;

  wire last = (cnt == CNT_W'(1));

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    next_st = st;
    case (st)
      SPT_IDLE:  if (i_req) next_st = SPT_SETUP;
      SPT_SETUP: next_st = SPT_STRB;
      SPT_STRB:  if (last) next_st = SPT_RECOV;
      SPT_RECOV: if (last) next_st = SPT_IDLE;
      default:   next_st = SPT_IDLE;
    endcase
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      st      <= SPT_IDLE;
      cnt     <= '0;
      wr_mode <= 1'b0;
      ctl     <= CTL_IDLE;
      o_done  <= 1'b0;
      d_s1    <= BUS_IDLE;
      d_s2    <= BUS_IDLE;
      o_rdata <= DATA_RST;
      pins.d_host_o  <= DATA_RST;
      pins.d_host_oe <= 1'b0;
    end
    else
    begin
      st     <= next_st;
      d_s1   <= pins.d_bus;
      d_s2   <= d_s1;
      o_done <= (st == SPT_RECOV) && last;
      case (st)
        SPT_IDLE:
          if (i_req)
          begin
            wr_mode        <= i_write;
            pins.d_host_o  <= i_wdata;
            pins.d_host_oe <= i_write; // [R6]
            ctl[PIN_CS]    <= 1'b0;    // [R7]
          end
        SPT_SETUP:
        begin
          cnt <= CNT_W'(STRB_CYC);
          if (wr_mode)
            ctl[PIN_WR] <= 1'b0; // [R6]
          else
            ctl[PIN_RD] <= 1'b0; // [R5]
        end
        SPT_STRB:
        begin
          cnt <= last ? CNT_W'(RECOV_LEN) : cnt - CNT_W'(1);
          if (last)
          begin
            ctl[PIN_RD] <= 1'b1;
            ctl[PIN_WR] <= 1'b1;
            if (!wr_mode)
              o_rdata <= d_s2; // [R5]
          end
        end
        SPT_RECOV:
        begin
          cnt <= cnt - CNT_W'(1);
          // Data held past the strobe so the slave's late sample is safe
          if (last)
          begin
            ctl[PIN_CS]    <= 1'b1;
            pins.d_host_oe <= 1'b0;
          end
        end
        default:
          ctl <= CTL_IDLE;
      endcase
    end
  end

  assign o_busy         = (st != SPT_IDLE);
  assign pins.c_host_o  = ctl;
  assign pins.c_host_oe = 1'b1;

endmodule : spt_host

`default_nettype wire

// *** spt_chk.sv ***
`timescale 1ns/100ps
`default_nettype none

module spt_chk (
  input wire logic       i_mclk,      // System clock
  input wire logic       i_rst,       // Sync reset
  input wire logic [7:0] i_d_dev_oe,  // Device data enables
  input wire logic       i_d_host_oe, // Host data enable
  input wire logic [2:0] i_c_dev_oe,  // Device pin enables
  input wire logic [7:0] i_d_bus,     // Resolved data wires
  input wire logic [2:0] i_c_bus      // Resolved control wires
);
  // ----------------------------------------------------------------
  // Link timing
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_rst);

  sequence rd_start;
    $fell(i_c_bus[0]) && !i_c_bus[2];
  endsequence

  // Strobe stays low for the full host width, then lifts
  sequence wr_pulse;
    !i_c_bus[1] [*8] ##1 i_c_bus[1];
  endsequence

  a_no_fight: assert property (!(i_d_host_oe && i_d_dev_oe != 8'h00))
    else $error("data wires driven from both ends");
  a_strobe_sel: assert property (i_c_bus[1:0] != 2'h3 |-> !i_c_bus[2])
    else $error("strobe active without select");
  a_one_strobe: assert property (i_c_bus[1:0] != 2'h0)
    else $error("read and write strobes both active");
  a_sel_lead: assert property (
    ($fell(i_c_bus[1]) || $fell(i_c_bus[0]))
    |-> $past(i_c_bus[2]) == 1'b0)
    else $error("select did not lead the strobe");
  a_wr_width: assert property ($fell(i_c_bus[1]) |-> wr_pulse)
    else $error("write strobe width wrong");
  a_wr_hold: assert property (
    (!i_c_bus[1] && !$past(i_c_bus[1]))
    |-> $stable(i_d_bus))
    else $error("data moved during write strobe");
  a_rd_drive: assert property (rd_start
    |-> ##[1:4] i_d_dev_oe == 8'hff)
    else $error("device did not drive the read word");
  a_rd_release: assert property ($rose(i_c_bus[2])
    |-> ##[0:4] i_d_dev_oe == 8'h00)
    else $error("device kept driving after select");
  a_pins_in: assert property (!i_c_bus[2] |-> i_c_dev_oe == 3'h0)
    else $error("device drove a control pin in slave use");
endmodule : spt_chk

`default_nettype wire

// *** tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none

`define CHK(g, e) \
  begin \
    check_count++; \
    if ((g) !== (e)) \
    begin \
      n_fail++; \
      $display("BAD t=%0t got=%h exp=%h", $time, g, e); \
    end \
  end

module tb_top;
  import spt_pkg::*;

  logic        i_mclk, i_rst, awvalid, wvalid, bready, arvalid, rready;
  logic [9:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0]  bresp, rresp;
  logic        h_req, h_write, h_busy, h_done;
  logic [7:0]  h_wdata, h_rdata, hrd;
  int          n_fail, check_count, cyc;
  logic [31:0] np_rdata, np_d;
  logic [1:0]  wr_resp;
  logic        np_irq;

  spt_if pins ();

  spt_device u_spt_device (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_awaddr(awaddr),
    .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata),
    .i_wstrb(4'hf), .i_wvalid(wvalid), .o_wready(wready),
    .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
    .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
    .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
    .i_rready(rready), .o_irq(irq), .pins(pins)
  );

  spt_host u_spt_host (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_req(h_req), .i_write(h_write),
    .i_wdata(h_wdata), .o_busy(h_busy), .o_done(h_done),
    .o_rdata(h_rdata), .pins(pins)
  );

  // Variant without the port shares the register bus; only its read data and irq are kept
  spt_if pins_np ();
  assign pins_np.d_host_o  = BUS_IDLE;
  assign pins_np.d_host_oe = 1'b0;
  assign pins_np.c_host_o  = CTL_IDLE;
  assign pins_np.c_host_oe = 1'b0;

  spt_device #(
    .HAS_PORT(1'b0)
  ) u_spt_device_np (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_awaddr(awaddr),
    .i_awvalid(awvalid), .o_awready(), .i_wdata(wdata),
    .i_wstrb(4'hf), .i_wvalid(wvalid), .o_wready(),
    .o_bresp(), .o_bvalid(), .i_bready(bready),
    .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(),
    .o_rdata(np_rdata), .o_rresp(), .o_rvalid(),
    .i_rready(rready), .o_irq(np_irq), .pins(pins_np)
  );

  spt_chk u_spt_chk (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_d_dev_oe(pins.d_dev_oe),
    .i_d_host_oe(pins.d_host_oe), .i_c_dev_oe(pins.c_dev_oe),
    .i_d_bus(pins.d_bus), .i_c_bus(pins.c_bus)
  );

  always #50 i_mclk = ~i_mclk;

  // ----------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------
  task automatic axi_wr(input logic [7:0] idx, input logic [7:0] v);
    awaddr  <= {idx, 2'b00};
    wdata   <= {24'h0, v};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do @(posedge i_mclk); while (awready !== 1'b1);
    awvalid <= 1'b0;
    wvalid  <= 1'b0;
    do @(posedge i_mclk); while (bvalid !== 1'b1);
    wr_resp = bresp;
    bready <= 1'b0;
    @(posedge i_mclk);
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] idx, output logic [31:0] d,
                        output logic [1:0] r);
    araddr  <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge i_mclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge i_mclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    np_d = np_rdata;
    rready <= 1'b0;
    @(posedge i_mclk);
  endtask : axi_rd

  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(idx, d, r);
    `CHK(r, RESP_OKAY)
    `CHK(d, {24'h0, e})
  endtask : rd_chk

  // Pins need a few cycles to pass the device's synchronisers
  task automatic host_xfer(input logic w, input logic [7:0] v);
    h_req   <= 1'b1;
    h_write <= w;
    h_wdata <= v;
    @(posedge i_mclk);
    h_req <= 1'b0;
    @(posedge i_mclk);
    `CHK(h_busy, 1'b1)
    do @(posedge i_mclk); while (h_done !== 1'b1);
    hrd = h_rdata;
    repeat (4) @(posedge i_mclk);
  endtask : host_xfer

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    logic [31:0] d;
    logic [1:0]  r;
    rd_chk(IDX_CTRL, 8'h07);
    `CHK(np_d, 32'h0)
    rd_chk(IDX_FLAGS, 8'h00);
    rd_chk(IDX_EN, 8'h00);
    rd_chk(IDX_DDIR, 8'hff);
    `CHK(np_d, 32'h0)
    `CHK(irq, 1'b0)
    `CHK(np_irq, 1'b0)
    axi_rd(8'h00, d, r);
    `CHK(r, RESP_SLVERR)
    axi_wr(8'h01, 8'h00);
    `CHK(wr_resp, RESP_SLVERR)
    $display("t_reset done");
  endtask : t_reset

  task automatic t_nomode;
    host_xfer(1'b1, 8'h99);
    rd_chk(IDX_CTRL, 8'h07);
    rd_chk(IDX_FLAGS, 8'h00);
    $display("t_nomode done");
  endtask : t_nomode

  task automatic t_ext_read;
    axi_wr(IDX_CTRL, 8'h17);
    axi_wr(IDX_DATA, 8'h3c);
    `CHK(wr_resp, RESP_OKAY)
    rd_chk(IDX_CTRL, 8'h57);
    host_xfer(1'b0, 8'h00);
    `CHK(hrd, 8'h3c)
    rd_chk(IDX_CTRL, 8'h17);
    $display("t_ext_read done");
  endtask : t_ext_read

  task automatic t_ext_write;
    axi_wr(IDX_EN, 8'h80);
    rd_chk(IDX_FLAGS, 8'h00);
    host_xfer(1'b1, 8'ha5);
    rd_chk(IDX_CTRL, 8'h97);
    `CHK(irq, 1'b1)
    rd_chk(IDX_FLAGS, 8'h80);
    rd_chk(IDX_FLAGS, 8'h00);
    `CHK(irq, 1'b0)
    rd_chk(IDX_DATA, 8'ha5);
    rd_chk(IDX_CTRL, 8'h17);
    $display("t_ext_write done");
  endtask : t_ext_write

  task automatic t_overflow;
    axi_wr(IDX_EN, 8'h00);
    host_xfer(1'b1, 8'h11);
    host_xfer(1'b1, 8'h22);
    `CHK(irq, 1'b0)
    rd_chk(IDX_CTRL, 8'hb7);
    rd_chk(IDX_DATA, 8'h22);
    rd_chk(IDX_CTRL, 8'h37);
    axi_wr(IDX_CTRL, 8'h17);
    rd_chk(IDX_CTRL, 8'h17);
    $display("t_overflow done");
  endtask : t_overflow

  task automatic t_gpio;
    axi_wr(IDX_PINS, 8'h07);
    axi_wr(IDX_CTRL, 8'h08);
    rd_chk(IDX_CTRL, 8'h00);
    `CHK(pins.c_dev_oe, 3'h7)
    `CHK(pins.c_bus, 3'h7)
    axi_wr(IDX_CTRL, 8'h10);
    `CHK(pins.c_dev_oe, 3'h0)
    axi_wr(IDX_CTRL, 8'h07);
    axi_wr(IDX_DDIR, 8'h00);
    axi_wr(IDX_DATA, 8'h5a);
    `CHK(pins.d_bus, 8'h5a)
    axi_wr(IDX_DDIR, 8'hff);
    `CHK(pins.d_dev_oe, 8'h00)
    $display("t_gpio done");
  endtask : t_gpio

  task automatic test_done;
    $display("checks=%0d fails=%0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : test_done

  // Whole run needs under 1000 cycles
  always @(posedge i_mclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_fail++;
      test_done;
    end
  end

  initial
  begin
    i_mclk  = 1'b0;
    i_rst   = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata} = 52'h0;
    {h_req, h_write, h_wdata} = 10'h000;
    repeat (3) @(posedge i_mclk);
    i_rst <= 1'b0;
    t_reset;
    t_nomode;
    t_ext_read;
    t_ext_write;
    t_overflow;
    t_gpio;
    test_done;
  end
endmodule : tb_top

`default_nettype wire
